// *** rtl/acs_pkg.sv ***
// Package for the converter sequencer: register layout, timing, states
package acs_pkg;
    localparam int CAL_WIDTH        = 16;
    localparam int CAL_DATA_WIDTH   = 14;
    localparam int RESULT_WIDTH     = 12;
    localparam int DATA_BUS_WIDTH   = 16;
    // Register select codes on the parallel port address pins
    localparam logic [1:0] SEL_CONTROL = 2'h0;
    localparam logic [1:0] SEL_OFFSET  = 2'h1;
    localparam logic [1:0] SEL_GAIN    = 2'h2;
    localparam logic [1:0] SEL_RESULT  = 2'h3;
    // Control word fields
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_BIPOLAR_BIT = 1;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    // Mid-scale correction values after reset
    localparam logic [13:0] OFFSET_RESET = 14'h2000;
    localparam logic [13:0] GAIN_RESET   = 14'h2000;
    // Conversion length in half periods of the master clock
    localparam int CONV_HALF_PERIODS      = 33;
    localparam int CONV_HALF_PERIODS_LATE = 35;
    localparam int SETUP_NS       = 10;
    localparam int CLK_PERIOD_NS  = 20;
    // Setup shorter than a cycle: a start seen on the edge is taken as within setup
    localparam int SETUP_CYCLES   = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CAL_TIME_US    = 1000;
    localparam int CAL_CYCLES     = CAL_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int CNT_WIDTH      = 16;

    typedef enum logic [1:0] {
        ACS_IDLE    = 2'b00,
        ACS_CONVERT = 2'b01,
        ACS_LATCH   = 2'b11,
        ACS_CAL     = 2'b10
    } acs_state_type;
endpackage

// *** rtl/acs_cal_regs.sv ***
// Offset and gain correction register pair with byte-wise access
`timescale 1ns/1ns
module acs_cal_regs (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic                       wr_en,
    input  wire logic                       sel_gain,
    input  wire logic                       high_byte_select,
    input  wire logic                       byte_mode,
    input  wire logic [15:0]                wr_data,
    input  wire logic                       cal_load,
    input  wire logic [13:0]                cal_offset,
    input  wire logic [13:0]                cal_gain,
    output logic      [acs_pkg::CAL_WIDTH-1:0] offset_correction,
    output logic      [acs_pkg::CAL_WIDTH-1:0] gain_correction,
    output logic                            pointer_advance
);
    import acs_pkg::*;

    logic [CAL_DATA_WIDTH-1:0] offset_q;
    logic [CAL_DATA_WIDTH-1:0] gain_q;
    logic [7:0]                low_hold;

    // =============================================
    // Storage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            offset_q <= OFFSET_RESET;
            gain_q   <= GAIN_RESET;
            low_hold <= 8'h00;
        end else if (cal_load) begin
            offset_q <= cal_offset;
            gain_q   <= cal_gain;
        end else if (wr_en) begin
            if (byte_mode && !high_byte_select) begin
                low_hold <= wr_data[7:0];
            end else if (byte_mode) begin
                // Word commits only on the high byte so halves never tear
                if (sel_gain) begin
                    gain_q <= {wr_data[5:0], low_hold};
                end else begin
                    offset_q <= {wr_data[5:0], low_hold};
                end
            end else if (sel_gain) begin
                gain_q <= wr_data[13:0];
            end else begin
                offset_q <= wr_data[13:0];
            end
        end
    end

    assign pointer_advance   = wr_en && (!byte_mode || high_byte_select);
    assign offset_correction = {2'b00, offset_q};
    assign gain_correction   = {2'b00, gain_q};
endmodule

// *** rtl/acs_sequencer.sv ***
// Conversion sequencer: start, track/hold, timing, busy, calibration, result port
// =============================================
`timescale 1ns/1ns
module acs_sequencer #(
    parameter int CAL_CYCLES_P = acs_pkg::CAL_CYCLES
) (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          conv_start_n,
    input  wire logic                          cs_n,
    input  wire logic                          rd_n,
    input  wire logic                          wr_n,
    input  wire logic [1:0]                    reg_sel,
    input  wire logic                          byte_mode,
    input  wire logic                          high_byte_select,
    input  wire logic [15:0]                   data_in,
    input  wire logic [11:0]                   sar_code,
    input  wire logic [13:0]                   sar_cal_offset,
    input  wire logic [13:0]                   sar_cal_gain,
    output logic      [15:0]                   data_out,
    output logic                               data_oe_n,
    output logic                               busy,
    output logic                               track_hold,
    output logic                               sar_run,
    output logic                               cal_run,
    output logic      [acs_pkg::CAL_WIDTH-1:0] offset_correction,
    output logic      [acs_pkg::CAL_WIDTH-1:0] gain_correction,
    output logic                               cal_pointer_advance
);
    import acs_pkg::*;

    // =============================================
    // Pin synchronisers
    logic [2:0] start_sync;
    logic [2:0] wr_sync;
    logic [1:0] rd_sync;
    logic [1:0] cs_sync;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_sync <= 3'h7;
            wr_sync    <= 3'h7;
            rd_sync    <= 2'h3;
            cs_sync    <= 2'h3;
        end else begin
            start_sync <= {start_sync[1:0], conv_start_n};
            wr_sync    <= {wr_sync[1:0], wr_n};
            rd_sync    <= {rd_sync[0], rd_n};
            cs_sync    <= {cs_sync[0], cs_n};
        end
    end

    // =============================================
    // Address, mode and data pins
    // Quasi-static: held steady well before the synced strobe edge is seen
    logic [19:0] bus_pins_s1;
    logic [19:0] bus_pins_s2;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bus_pins_s1 <= 20'h00000;
            bus_pins_s2 <= 20'h00000;
        end else begin
            bus_pins_s1 <= {reg_sel, byte_mode, high_byte_select, data_in};
            bus_pins_s2 <= bus_pins_s1;
        end
    end

    logic [1:0]  reg_sel_s;
    logic        byte_mode_s;
    logic        high_byte_s;
    logic [15:0] data_in_s;
    assign reg_sel_s   = bus_pins_s2[19:18];
    assign byte_mode_s = bus_pins_s2[17];
    assign high_byte_s = bus_pins_s2[16];
    assign data_in_s   = bus_pins_s2[15:0];

    logic start_rise;
    logic wr_end;
    logic sel;
    logic bus_write;
    assign start_rise = start_sync[1] && !start_sync[2];
    assign wr_end     = wr_sync[1] && !wr_sync[2];
    assign sel        = !cs_sync[1];
    assign bus_write  = wr_end && sel;

    // =============================================
    // Control register
    logic [15:0]   control;
    logic          first_done;
    logic [CNT_WIDTH+6:0] count;
    logic          sw_start;
    logic          start_req;
    logic          busy_fall;
    logic [11:0]   result;
    acs_state_type state;

    // Start accepted at end of write (or rising edge of pin)
    assign sw_start  = bus_write && reg_sel_s == SEL_CONTROL
                       && data_in_s[CTRL_START_BIT];
    assign start_req = start_rise || sw_start;
    assign busy_fall = state == ACS_LATCH || (state == ACS_CAL && count == 0);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            control <= CONTROL_RESET;
        end else if (bus_write && reg_sel_s == SEL_CONTROL) begin
            control <= data_in_s;
        end else if (busy_fall) begin
            control[CTRL_START_BIT] <= 1'b0;
        end
    end

    // =============================================
    // Sequencer
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state      <= ACS_IDLE;
            count      <= '0;
            first_done <= 1'b0;
        end else begin
            case (state)
                ACS_IDLE: begin
                    if (start_req && !first_done) begin
                        state      <= ACS_CAL;
                        first_done <= 1'b1;
                        count      <= (CNT_WIDTH+7)'(CAL_CYCLES_P - 1);
                    end else if (start_req) begin
                        state <= ACS_CONVERT;
                        // Edge seen late through sync; always within setup: shorter case
                        count <= (CNT_WIDTH+7)'((CONV_HALF_PERIODS + 1) / 2 - 1);
                    end
                end
                ACS_CONVERT: begin
                    if (count == 0) begin
                        state <= ACS_LATCH;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                ACS_LATCH: begin
                    state <= ACS_IDLE;
                end
                ACS_CAL: begin
                    if (count == 0) begin
                        state <= ACS_IDLE;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                default: begin
                    state <= ACS_IDLE;
                end
            endcase
        end
    end

    // Busy held from acceptance until result latched
    assign busy       = state != ACS_IDLE;
    assign track_hold = busy;
    assign sar_run    = state == ACS_CONVERT;
    assign cal_run    = state == ACS_CAL;

    // =============================================
    // Result register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            result <= 12'h000;
        end else if (state == ACS_LATCH) begin
            if (control[CTRL_BIPOLAR_BIT]) begin
                result <= {~sar_code[11], sar_code[10:0]};
            end else begin
                result <= sar_code;
            end
        end
    end

    // =============================================
    // Read port
    logic [15:0] next_data_out;
    always_comb begin
        case (reg_sel_s)
            SEL_CONTROL: next_data_out = {12'h000, 1'b0, 1'b0, control[1:0]};
            SEL_OFFSET:  next_data_out = offset_correction;
            SEL_GAIN:    next_data_out = gain_correction;
            SEL_RESULT:  next_data_out = {4'h0, result};
            default:     next_data_out = 16'h0000;
        endcase
        if (byte_mode_s) begin
            next_data_out = high_byte_s ? {8'h00, next_data_out[15:8]}
                                        : {8'h00, next_data_out[7:0]};
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            data_out  <= 16'h0000;
            data_oe_n <= 1'b1;
        end else begin
            data_out  <= next_data_out;
            data_oe_n <= !(sel && !rd_sync[1]);
        end
    end

    // =============================================
    // Calibration registers
    logic cal_wr;
    logic cal_load;
    assign cal_wr   = bus_write && (reg_sel_s == SEL_OFFSET || reg_sel_s == SEL_GAIN);
    assign cal_load = state == ACS_CAL && count == 0;

    acs_cal_regs u_cal (
        .mclk              (mclk),
        .rst               (rst),
        .wr_en             (cal_wr),
        .sel_gain          (reg_sel_s == SEL_GAIN),
        .high_byte_select  (high_byte_s),
        .byte_mode         (byte_mode_s),
        .wr_data           (data_in_s),
        .cal_load          (cal_load),
        .cal_offset        (sar_cal_offset),
        .cal_gain          (sar_cal_gain),
        .offset_correction (offset_correction),
        .gain_correction   (gain_correction),
        .pointer_advance   (cal_pointer_advance)
    );
endmodule

// *** dv/acs_asserts.sv ***
// Port checker for the conversion sequencer
`timescale 1ns/1ns
module acs_asserts #(
    parameter int CAL_CYCLES_P = acs_pkg::CAL_CYCLES
) (
    input wire logic                          mclk,
    input wire logic                          rst,
    input wire logic                          conv_start_n,
    input wire logic                          cs_n,
    input wire logic                          rd_n,
    input wire logic                          byte_mode,
    input wire logic                          high_byte_select,
    input wire logic                          data_oe_n,
    input wire logic                          busy,
    input wire logic                          track_hold,
    input wire logic                          sar_run,
    input wire logic                          cal_run,
    input wire logic [acs_pkg::CAL_WIDTH-1:0] offset_correction,
    input wire logic [acs_pkg::CAL_WIDTH-1:0] gain_correction,
    input wire logic                          cal_pointer_advance
);
    import acs_pkg::*;
    // ========
    // Helpers
    logic [15:0] busy_cnt;
    logic        was_cal;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Length of the current busy span, and whether it was a calibration
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_cnt <= 16'h0;
            was_cal  <= 1'b0;
        end else begin
            busy_cnt <= busy ? busy_cnt + 16'h1 : 16'h0;
            was_cal  <= busy & (was_cal | cal_run);
        end
    end
    a_track_follows: assert property (track_hold == busy)
        else $error("track/hold differs from busy");
    a_offset_top: assert property (offset_correction[15:14] == 2'h0)
        else $error("offset top bits set");
    a_gain_top: assert property (gain_correction[15:14] == 2'h0)
        else $error("gain top bits set");
    a_conv_length: assert property ($fell(busy) && busy_cnt != 0 && !was_cal
        |-> busy_cnt == 16'((CONV_HALF_PERIODS + 1) / 2 + 1))
        else $error("conversion length wrong");
    a_cal_length: assert property ($fell(busy) && was_cal
        |-> busy_cnt >= CAL_CYCLES_P) else $error("calibration too short");
    a_start_accept: assert property ($rose(conv_start_n) && !busy |-> ##[1:5] busy)
        else $error("start pin not accepted");
    a_read_drive: assert property ((!cs_n && !rd_n) [*4] |-> !data_oe_n)
        else $error("read does not drive bus");
    a_read_release: assert property (rd_n [*4] |-> data_oe_n)
        else $error("bus driven without read");
    a_pointer_high: assert property (cal_pointer_advance && byte_mode
        |-> high_byte_select) else $error("pointer moved off high byte");
    a_run_busy: assert property ($fell(sar_run) |-> busy && !cal_run ##1 !busy)
        else $error("busy not held through latch");
    c_conv: cover property ($fell(busy) && !was_cal);
    c_cal: cover property (cal_run);
    c_ptr: cover property (cal_pointer_advance);
endmodule

// *** dv/acs_host.sv ***
// Host processor model on the parallel port and start pin
`timescale 1ns/1ns
module acs_host (
    input  wire logic        mclk,
    input  wire logic [15:0] data_out,
    output logic             conv_start_n,
    output logic             cs_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic [1:0]       reg_sel,
    output logic             byte_mode,
    output logic             high_byte_select,
    output logic [15:0]      data_in
);
    import acs_pkg::*;
    // ========
    // Bus cycles
    initial begin
        {conv_start_n, cs_n, rd_n, wr_n} = 4'hf;
        {reg_sel, byte_mode, high_byte_select} = 4'h0;
        data_in = 16'h0;
    end
    // Everything held four cycles past the write end: the pins are synchronised
    task automatic wr(input logic [1:0] sel, input logic [15:0] d, input logic bm,
                      input logic hb);
        @(negedge mclk);
        {cs_n, wr_n, reg_sel, data_in, byte_mode, high_byte_select} = {2'h0, sel, d, bm, hb};
        repeat (4) @(negedge mclk);
        wr_n = 1'b1;
        repeat (4) @(negedge mclk);
        cs_n = 1'b1;
        data_in = ~d;
    endtask
    // Control write with the strobe held n cycles, to outlast busy
    task automatic wr_late(input logic [15:0] d, input int n);
        @(negedge mclk);
        {cs_n, wr_n, reg_sel, data_in, byte_mode} = {2'h0, SEL_CONTROL, d, 1'b0};
        repeat (n) @(negedge mclk);
        wr_n = 1'b1;
        repeat (4) @(negedge mclk);
        cs_n = 1'b1;
    endtask
    task automatic rd(input logic [1:0] sel, output logic [15:0] d);
        @(negedge mclk);
        {cs_n, rd_n, reg_sel, byte_mode} = {2'h0, sel, 1'b0};
        repeat (6) @(negedge mclk);
        d = data_out;
        {cs_n, rd_n} = 2'h3;
    endtask
    task automatic start_pulse;
        repeat (25) @(negedge mclk);
        conv_start_n = 1'b0;
        repeat (3) @(negedge mclk);
        conv_start_n = 1'b1;
    endtask
endmodule

// *** dv/acs_sequencer_tb.sv ***
// Self-checking testbench for the conversion sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module acs_sequencer_tb;
    import acs_pkg::*;
    logic        mclk, rst, conv_start_n, cs_n, rd_n, wr_n, byte_mode, high_byte_select;
    logic        data_oe_n, busy, track_hold, sar_run, cal_run, cal_pointer_advance;
    logic [1:0]  reg_sel;
    logic [11:0] sar_code;
    logic [13:0] sar_cal_offset, sar_cal_gain;
    logic [15:0] data_in, data_out, offset_correction, gain_correction, rdata;
    int          errors, n_tests;
    always #10 mclk = ~mclk;
    acs_host u_acs_host (.mclk, .data_out, .conv_start_n, .cs_n, .rd_n, .wr_n, .reg_sel,
        .byte_mode, .high_byte_select, .data_in);
    acs_sequencer #(.CAL_CYCLES_P(10)) u_acs_sequencer (.mclk, .rst, .conv_start_n, .cs_n,
        .rd_n, .wr_n, .reg_sel, .byte_mode, .high_byte_select, .data_in, .sar_code,
        .sar_cal_offset, .sar_cal_gain, .data_out, .data_oe_n, .busy, .track_hold, .sar_run,
        .cal_run, .offset_correction, .gain_correction, .cal_pointer_advance);
    // ========
    // Tests
    task automatic stop_test;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wait_done;
        int i;
        i = 0;
        while (busy !== 1'b1 && i < 20) begin @(negedge mclk); i++; end
        while (busy !== 1'b0 && i < 200) begin @(negedge mclk); i++; end
        `CHK(i < 200, 1'b1)
    endtask
    initial begin
        {mclk, rst, errors, n_tests} = {2'b01, 32'd0, 32'd0};
        {sar_code, sar_cal_offset, sar_cal_gain} = {12'ha5c, 14'h3abc, 14'h1234};
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        `CHK(offset_correction, 16'h2000)
        `CHK(gain_correction, 16'h2000)
        u_acs_host.start_pulse();
        wait_done();
        `CHK(offset_correction, 16'h3abc)
        `CHK(gain_correction, 16'h1234)
        u_acs_host.start_pulse();
        wait_done();
        u_acs_host.rd(SEL_RESULT, rdata);
        `CHK(rdata[11:0], 12'ha5c)
        sar_code = 12'h812;
        // Software start in both codings; start bit must be clear afterwards
        for (int m = 0; m < 2; m++) begin
            repeat (25) @(negedge mclk);
            u_acs_host.wr(SEL_CONTROL, {14'h0, m[0], 1'b1}, 1'b0, 1'b0);
            wait_done();
            u_acs_host.rd(SEL_RESULT, rdata);
            `CHK(rdata[11:0], m ? 12'h012 : 12'h812)
            u_acs_host.rd(SEL_CONTROL, rdata);
            `CHK(rdata[1:0], {m[0], 1'b0})
        end
        u_acs_host.wr(SEL_OFFSET, 16'hffff, 1'b0, 1'b0);
        u_acs_host.rd(SEL_OFFSET, rdata);
        `CHK(rdata, 16'h3fff)
        u_acs_host.wr(SEL_GAIN, 16'h0034, 1'b1, 1'b0);
        `CHK(gain_correction, 16'h1234)
        u_acs_host.wr(SEL_GAIN, 16'h00ff, 1'b1, 1'b1);
        `CHK(gain_correction, 16'h3f34)
        // Second write held past busy fall must restart at once: short acquisition
        u_acs_host.wr(SEL_CONTROL, 16'h0001, 1'b0, 1'b0);
        u_acs_host.wr_late(16'h0001, 18);
        `CHK(busy, 1'b1)
        wait_done();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        stop_test();
    end
endmodule
bind acs_sequencer acs_asserts #(.CAL_CYCLES_P(CAL_CYCLES_P)) u_acs_asserts (.mclk, .rst,
    .conv_start_n, .cs_n, .rd_n, .byte_mode, .high_byte_select, .data_oe_n, .busy,
    .track_hold, .sar_run, .cal_run, .offset_correction, .gain_correction,
    .cal_pointer_advance);
